// ### inc/sdc_pkg.sv
/*
 package for the step/direction command input block: constants, modes and carriers.
 assumes a single 100 MHz core clock and active-low asynchronous reset.
*/
package sdc_pkg;
    // core clock
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;
    // least step pulse width the drive must catch, in ns
    localparam int MIN_PULSE_NS = 2500;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // direction set-up time before the step edge, in ns
    localparam int DIR_SETUP_NS = 5000;
    localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // soft-start interval after enable, in ms
    localparam int SOFT_START_MS = 100;
    localparam int SOFT_START_CYC = SOFT_START_MS * 1000 * CLK_MHZ;
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
    // reset values of configuration
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_EDGE = 1'b0;

    typedef enum logic [0:0] {
        SDC_MODE_PULSE_DIR = 1'b0,
        SDC_MODE_CW_CCW = 1'b1
    } sdc_mode_e;

    typedef enum logic [2:0] {
        SDC_ST_OFF = 3'b001,
        SDC_ST_SOFT = 3'b010,
        SDC_ST_RUN = 3'b100
    } sdc_state_e;

    // configuration from the tuning side
    typedef struct packed {
        sdc_mode_e mode;
        logic falling_edge;
        logic cw_active_low;
        logic ccw_active_low;
        logic gate_active_low;
    } sdc_cfg_s;

    // protection sources
    typedef struct packed {
        logic over_volt;
        logic under_volt;
        logic over_curr;
        logic phase_err;
        logic over_temp;
    } sdc_prot_s;

    // step command out
    typedef struct packed {
        logic step;
        logic ccw;
    } sdc_cmd_s;
endpackage

// ### rtl/sdc_sync.sv
/*
 two-stage synchroniser plus edge detect for one isolated input.
 assumes the input is asynchronous to i_clk.
*/
`timescale 1ns/1ns
module sdc_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // pin side
    input wire logic i_pin,
    // synchronous side
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    import sdc_pkg::*;

    logic [SYNC_STAGES-1:0] stage;
    logic [SYNC_STAGES-1:0] next_stage;
    logic last;
    logic next_last;

    always_comb begin
        next_stage = {stage[SYNC_STAGES-2:0], i_pin};
        next_last = stage[SYNC_STAGES-1];
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stage <= '0;
            last <= 1'b0;
        end else begin
            stage <= next_stage;
            last <= next_last;
        end
    end

    // edge detect only reads the final stage, never the first
    assign o_level = stage[SYNC_STAGES-1];
    assign o_rise = stage[SYNC_STAGES-1] & ~last;
    assign o_fall = ~stage[SYNC_STAGES-1] & last;
endmodule // sdc_sync

// ### rtl/sdc_soft.sv
/*
 soft-start timer: counts the interval after the drive is enabled.
 assumes i_gate is already synchronous.
*/
`timescale 1ns/1ns
module sdc_soft #(
    parameter int SOFT_CYC = sdc_pkg::SOFT_START_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_gate,
    // status
    output logic o_busy
);
    import sdc_pkg::*;

    logic [31:0] cnt;
    logic [31:0] next_cnt;

    always_comb begin
        if (!i_gate) begin
            next_cnt = 32'(SOFT_CYC);
        end else if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
        end else begin
            next_cnt = cnt;
        end
    end

    // starts busy so power-up also gets the ramp
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 32'(SOFT_CYC);
        end else begin
            cnt <= next_cnt;
        end
    end

    assign o_busy = (cnt != 32'h0);
endmodule // sdc_soft

// ### rtl/sdc_top.sv
/*
 command input front end of a stepper drive: step, direction and gate inputs
 become step and direction commands; fault output reflects protections.
 assumes opto-isolated pins asynchronous to I_CLK and configuration held static.
*/
// How it works
// RQ1 - pulse/direction: one step per chosen active edge of step input
// RQ2 - after reset: pulse/direction mode, rising edge active
// RQ3 - pulse/direction: direction input level gives rotation sense
// RQ4 - double pulse: step input is clockwise, direction input counter-clockwise
// RQ5 - controller pulses exceed 2.5 us; each such pulse is caught
// RQ6 - controller sets direction 5 us before the step edge
// RQ7 - sinking wiring: gate high enables the drive
// RQ8 - sourcing or differential wiring: gate low enables the drive
// RQ9 - an unconnected gate input keeps the drive enabled
// RQ10 - controller waits 100 ms after enabling before stepping
// RQ11 - fault output off (not driving) in normal operation
// RQ12 - fault output pulls low while any protection is active
// RQ13 - each isolated input passes two flip-flops before edge detection
// RQ14 - no step commands while disabled or while protection is active
`timescale 1ns/1ns
module sdc_top #(
    parameter int SOFT_CYC = sdc_pkg::SOFT_START_CYC
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // isolated command pins
    input wire logic I_STEP_PULSE_IN,
    input wire logic I_DIR_IN,
    input wire logic I_DRIVE_GATE_IN,
    // configuration
    input wire sdc_pkg::sdc_cfg_s I_CFG,
    input wire logic I_CFG_CLEAR,
    // protection sources
    input wire sdc_pkg::sdc_prot_s I_PROT,
    // step command
    output sdc_pkg::sdc_cmd_s O_CMD,
    // status
    output logic O_ENABLED,
    output logic O_SOFT_BUSY,
    // open-collector fault pin
    output logic O_FAULT,
    output logic O_FAULT_OE
);
    import sdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, one per isolated pin: step, direction, gate
    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic step_rise, step_fall;
    logic dir_lvl, dir_rise, dir_fall;
    logic gate_lvl;

    assign pin_raw = {I_DRIVE_GATE_IN, I_DIR_IN, I_STEP_PULSE_IN};

    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        sdc_sync u_sync ( // [RQ13]
            .i_clk(I_CLK),
            .i_rstn(I_RSTN),
            .i_pin(pin_raw[gi]),
            .o_level(pin_lvl[gi]),
            .o_rise(pin_rise[gi]),
            .o_fall(pin_fall[gi])
        );
    end

    // the gate acts on its level only, so its edge outputs go unused
    assign step_rise = pin_rise[0];
    assign step_fall = pin_fall[0];
    assign dir_lvl = pin_lvl[1];
    assign dir_rise = pin_rise[1];
    assign dir_fall = pin_fall[1];
    assign gate_lvl = pin_lvl[2];

    ////////////////////////////////////////////////////////////////////////
    // configuration register, cleared to defaults
    sdc_cfg_s cfg;
    sdc_cfg_s next_cfg;

    always_comb begin
        if (I_CFG_CLEAR) begin
            next_cfg = '0;
            next_cfg.mode = sdc_mode_e'(RST_MODE); // [RQ2]
            next_cfg.falling_edge = RST_EDGE; // [RQ2]
        end else begin
            next_cfg = I_CFG;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg <= '0;
            cfg.mode <= sdc_mode_e'(RST_MODE); // [RQ2]
            cfg.falling_edge <= RST_EDGE; // [RQ2]
        end else begin
            cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable and protection
    logic gate_on;
    logic prot_any;
    logic soft_busy;

    // sinking wiring: high enables; sourcing/differential: low enables.
    // an open sinking input floats high through the opto, so it reads enabled.
    assign gate_on = cfg.gate_active_low ? ~gate_lvl : gate_lvl; // [RQ7] [RQ8] [RQ9]
    assign prot_any = |I_PROT; // [RQ12]

    sdc_soft #(
        .SOFT_CYC(SOFT_CYC)
    ) u_soft (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_gate(gate_on),
        .o_busy(soft_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // drive state: off, soft-start ramp, running
    sdc_state_e state;
    sdc_state_e next_state;

    always_comb begin
        case (state)
            SDC_ST_OFF: begin
                next_state = gate_on ? SDC_ST_SOFT : SDC_ST_OFF;
            end
            SDC_ST_SOFT: begin
                if (!gate_on) begin
                    next_state = SDC_ST_OFF;
                end else if (!soft_busy) begin
                    next_state = SDC_ST_RUN;
                end else begin
                    next_state = SDC_ST_SOFT;
                end
            end
            SDC_ST_RUN: begin
                next_state = gate_on ? SDC_ST_RUN : SDC_ST_OFF;
            end
            default: begin
                next_state = SDC_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state <= SDC_ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step decode
    // steps are accepted during the ramp too; the controller is expected
    // to hold off, and dropping them would hide its mistake from the motor
    logic allow;
    logic pd_edge;
    logic cw_edge;
    logic ccw_edge;
    sdc_cmd_s cmd;
    sdc_cmd_s next_cmd;

    assign allow = (state != SDC_ST_OFF) && gate_on && !prot_any; // [RQ14]
    // one-cycle edge pulse per transition; a 2.5 us pulse spans 250 clocks
    assign pd_edge = cfg.falling_edge ? step_fall : step_rise; // [RQ1] [RQ5]
    // double pulse: active level entry of each line is the step event
    assign cw_edge = cfg.cw_active_low ? step_fall : step_rise; // [RQ4]
    assign ccw_edge = cfg.ccw_active_low ? dir_fall : dir_rise; // [RQ4]

    always_comb begin
        next_cmd.step = 1'b0;
        next_cmd.ccw = cmd.ccw;
        if (allow) begin
            if (cfg.mode == SDC_MODE_PULSE_DIR) begin
                if (pd_edge) begin
                    next_cmd.step = 1'b1; // [RQ1]
                    next_cmd.ccw = dir_lvl; // [RQ3] [RQ6]
                end
            end else if (cw_edge != ccw_edge) begin
                // simultaneous opposite steps cancel out
                next_cmd.step = 1'b1; // [RQ4]
                next_cmd.ccw = ccw_edge; // [RQ4]
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cmd <= '0;
        end else begin
            cmd <= next_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, registered from the next state so they track it exactly
    logic enabled;
    logic status_soft;
    logic next_enabled;
    logic next_status_soft;

    always_comb begin
        next_enabled = (next_state != SDC_ST_OFF);
        next_status_soft = (next_state == SDC_ST_SOFT);
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            enabled <= 1'b0;
            status_soft <= 1'b0;
        end else begin
            enabled <= next_enabled;
            status_soft <= next_status_soft;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault pin: open collector, only ever pulls low
    logic fault_oe;
    logic next_fault_oe;

    always_comb begin
        next_fault_oe = prot_any; // [RQ11] [RQ12]
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            fault_oe <= 1'b0;
        end else begin
            fault_oe <= next_fault_oe;
        end
    end

    assign O_CMD = cmd;
    assign O_FAULT = 1'b0;
    assign O_FAULT_OE = fault_oe; // [RQ11]
    assign O_ENABLED = enabled;
    assign O_SOFT_BUSY = status_soft;
endmodule // sdc_top

// ### bench/sdc_top_properties.sv
/*
 port assertions for sdc_top.
 assumes pins move only at I_CLK edges.
*/
`timescale 1ns/1ns
module sdc_top_properties
    import sdc_pkg::*;
#(
    parameter int SOFT_CYC = SOFT_START_CYC
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // pins and settings
    input wire logic I_STEP_PULSE_IN,
    input wire logic I_DIR_IN,
    input wire logic I_DRIVE_GATE_IN,
    input wire sdc_cfg_s I_CFG,
    input wire logic I_CFG_CLEAR,
    input wire sdc_prot_s I_PROT,
    // watched outputs
    input wire sdc_cmd_s O_CMD,
    input wire logic O_ENABLED,
    input wire logic O_SOFT_BUSY,
    input wire logic O_FAULT,
    input wire logic O_FAULT_OE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    ////////////////////////////////////////
    logic live;
    int busy_run;
    assign live = O_ENABLED && !(|I_PROT) && !I_CFG_CLEAR && !I_CFG.mode;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            busy_run <= 0;
        end else begin
            busy_run <= O_SOFT_BUSY ? busy_run + 1 : 0;
        end
    end
    sequence s_step_soon;
        ##[2:4] O_CMD.step;
    endsequence
    property p_rise; $rose(I_STEP_PULSE_IN) && live && !I_CFG.falling_edge |-> s_step_soon;
    endproperty
    property p_fall; $fell(I_STEP_PULSE_IN) && live && I_CFG.falling_edge |-> s_step_soon;
    endproperty
    property p_lag; $rose(I_STEP_PULSE_IN) |=> !O_CMD.step; endproperty
    property p_one; O_CMD.step |=> !O_CMD.step; endproperty
    property p_dir; O_CMD.step && live |-> O_CMD.ccw == I_DIR_IN; endproperty
    property p_gate_on;
        $rose(I_DRIVE_GATE_IN) && !I_CFG.gate_active_low && !(|I_PROT) |-> ##[1:4] O_ENABLED;
    endproperty
    property p_gate_off; (!I_DRIVE_GATE_IN && !I_CFG.gate_active_low)[*5] |-> !O_ENABLED;
    endproperty
    property p_prot; (|I_PROT)[*4] |-> !O_CMD.step; endproperty
    property p_flt_on; |I_PROT |=> O_FAULT_OE && !O_FAULT; endproperty
    property p_flt_off; !(|I_PROT) |=> !O_FAULT_OE; endproperty
    property p_soft; busy_run <= SOFT_CYC + 4; endproperty
    a_rise: assert property (p_rise) else $error("no step after rising edge");
    a_fall: assert property (p_fall) else $error("no step after falling edge");
    a_lag: assert property (p_lag) else $error("step came before sync");
    a_one: assert property (p_one) else $error("step longer than a cycle");
    a_dir: assert property (p_dir) else $error("direction sense wrong");
    a_gate_on: assert property (p_gate_on) else $error("gate did not enable");
    a_gate_off: assert property (p_gate_off) else $error("enabled with gate low");
    a_prot: assert property (p_prot) else $error("step under protection");
    a_flt_on: assert property (p_flt_on) else $error("fault not pulled");
    a_flt_off: assert property (p_flt_off) else $error("fault pulled idle");
    a_soft: assert property (p_soft) else $error("soft-start too long");
endmodule // sdc_top_properties

bind sdc_top sdc_top_properties #(.SOFT_CYC(SOFT_CYC)) sdc_top_properties_inst (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_STEP_PULSE_IN(I_STEP_PULSE_IN),
    .I_DIR_IN(I_DIR_IN), .I_DRIVE_GATE_IN(I_DRIVE_GATE_IN), .I_CFG(I_CFG),
    .I_CFG_CLEAR(I_CFG_CLEAR), .I_PROT(I_PROT), .O_CMD(O_CMD), .O_ENABLED(O_ENABLED),
    .O_SOFT_BUSY(O_SOFT_BUSY), .O_FAULT(O_FAULT), .O_FAULT_OE(O_FAULT_OE)
);

// ### bench/sdc_ctrl_model.sv
/*
 motion controller model driving step, direction and gate pins.
 assumes the caller returns control at a clock edge.
*/
`timescale 1ns/1ns
module sdc_ctrl_model
    import sdc_pkg::*;
(
    // clock
    input wire logic i_clk,
    // pins
    output logic o_step,
    output logic o_dir,
    output logic o_gate
);
    initial begin
        o_step = 1'b0;
        o_dir = 1'b0;
        o_gate = 1'b1;
    end
    ////////////////////////////////////////
    // direction settles before the step edge
    task automatic drive(input logic s, input logic d);
        @(posedge i_clk) o_dir <= d;
        repeat (DIR_SETUP_CYC) @(posedge i_clk);
        o_step <= s;
        repeat (MIN_PULSE_CYC) @(posedge i_clk);
    endtask
    // both pulse pins move in one cycle
    task automatic both(input logic v);
        @(posedge i_clk) o_step <= v;
        o_dir <= v;
        repeat (MIN_PULSE_CYC) @(posedge i_clk);
    endtask
    task automatic gate(input logic g);
        @(posedge i_clk) o_gate <= g;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // sdc_ctrl_model

// ### bench/sdc_top_tb.sv
/*
 self-checking bench for sdc_top with the controller model.
 assumes short soft-start via SOFT_CYC.
*/
`timescale 1ns/1ns
module sdc_top_tb;
    import sdc_pkg::*;
    localparam int SOFT = 20;
    logic clk = 1'b0;
    logic rstn;
    logic step_pin, dir_pin, gate_pin, cfg_clr, fault, fault_oe, enabled, soft_busy;
    sdc_cfg_s cfg;
    sdc_prot_s prot;
    sdc_cmd_s cmd;
    int err_count = 0;
    int check_count = 0;
    logic [7:0] n_step = 8'h00;
    logic [7:0] base;
    logic last_ccw;
    logic [10:0] r;
    // clear, cfg, step, dir, steps expected, ccw expected
    logic [10:0] rows [16] = '{11'h012, 11'h000, 11'h01B, 11'h008, 11'h118, 11'h102,
        11'h212, 11'h200, 11'h20B, 11'h200, 11'h2D0, 11'h2C2, 11'h2C8, 11'h2C3,
        11'h512, 11'h500};
    sdc_top #(.SOFT_CYC(SOFT)) sdc_top_inst (
        .I_CLK(clk), .I_RSTN(rstn), .I_STEP_PULSE_IN(step_pin), .I_DIR_IN(dir_pin),
        .I_DRIVE_GATE_IN(gate_pin), .I_CFG(cfg), .I_CFG_CLEAR(cfg_clr), .I_PROT(prot),
        .O_CMD(cmd), .O_ENABLED(enabled), .O_SOFT_BUSY(soft_busy), .O_FAULT(fault),
        .O_FAULT_OE(fault_oe)
    );
    sdc_ctrl_model m (.i_clk(clk), .o_step(step_pin), .o_dir(dir_pin), .o_gate(gate_pin));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (cmd.step === 1'b1) begin
            n_step <= n_step + 8'h01;
            last_ccw <= cmd.ccw;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        final_report();
    end
    ////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        cfg = '0;
        cfg_clr = 1'b0;
        prot = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        chk({7'h00, enabled}, 8'h01);
        repeat (SOFT + 10) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            base = n_step;
            cfg <= r[9:5];
            cfg_clr <= r[10];
            m.drive(r[4], r[3]);
            chk(n_step - base, {6'h00, r[2:1]});
            if (r[2:1] != 2'h0) chk({7'h00, last_ccw}, {7'h00, r[0]});
        end
        cfg_clr <= 1'b0;
        cfg <= 5'h00;
        m.gate(1'b0);
        chk({7'h00, enabled}, 8'h00);
        base = n_step;
        m.drive(1'b1, 1'b0);
        m.drive(1'b0, 1'b0);
        chk(n_step - base, 8'h00);
        m.gate(1'b1);
        chk({6'h00, enabled, soft_busy}, 8'h03);
        repeat (SOFT + 10) @(posedge clk);
        chk({7'h00, soft_busy}, 8'h00);
        cfg <= 5'h01;
        repeat (8) @(posedge clk);
        chk({7'h00, enabled}, 8'h00);
        m.gate(1'b0);
        chk({7'h00, enabled}, 8'h01);
        cfg <= 5'h00;
        m.gate(1'b1);
        repeat (SOFT + 10) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            prot <= sdc_prot_s'(5'h01 << i);
            repeat (3) @(posedge clk);
            chk({6'h00, fault_oe, fault}, 8'h02);
        end
        base = n_step;
        m.drive(1'b1, 1'b0);
        m.drive(1'b0, 1'b0);
        chk(n_step - base, 8'h00);
        prot <= '0;
        repeat (SOFT + 10) @(posedge clk);
        chk({7'h00, fault_oe}, 8'h00);
        cfg <= 5'h10;
        base = n_step;
        m.both(1'b1);
        m.both(1'b0);
        chk(n_step - base, 8'h00);
        cfg <= 5'h08;
        cfg_clr <= 1'b1;
        m.drive(1'b1, 1'b0);
        m.drive(1'b0, 1'b0);
        chk(n_step - base, 8'h01);
        cfg_clr <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk({4'h0, enabled, soft_busy, fault_oe, cmd.step}, 8'h00);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        chk({7'h00, enabled}, 8'h01);
        final_report();
    end
endmodule // sdc_top_tb
